// ### core_exec_pkg.sv
// Summary of operation
// - acc_plus_literal adds 8-bit literal to accumulator, sets carry, digit carry, zero.
// - acc_and_literal ANDs literal into accumulator, only zero flag changes, one cycle.
// - acc_plus_reg adds accumulator and file register, sets carry, digit carry, zero.
// - acc_and_reg ANDs accumulator with file register, only zero flag changes.
// - byte ops: destination bit 0 writes accumulator, 1 writes file register back.
// - bit_clear_reg forces chosen bit to zero, flags untouched, one cycle.
// - bit_set_reg forces chosen bit to one, flags untouched, one cycle.
// - bit ops read in phase two, modify in three, write whole register in four.
// - skip_if_bit_low with bit zero turns fetched next word into a nop.
// - skip_if_bit_high with bit one turns fetched next word into a nop.
// - bit tests never write in phase four and leave all flags unchanged.
// - call pushes incremented counter onto stack in phase two of first cycle.
// - call loads 11-bit literal into counter bits 10..0, two cycles, flags kept.
// - call fills counter bits 12..11 from counter_high_latch bits 4..3.
// - clear_reg writes 00h to file register and sets zero flag.
// - clear_acc zeroes accumulator and sets zero flag, low seven bits ignored.
// - watchdog_kick clears watchdog counter and its prescaler in one cycle.
// - watchdog_kick sets watchdog_expiry_flag and power_down_flag.
// - complement_reg inverts register, routes by destination bit, updates zero flag.
// - every instruction cycle spans four clock periods, phases one to four.
// - low seven bits address file register, bit ops hold bit number above.
`default_nettype none
package core_exec_pkg;
    localparam int PC_W = 13;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int BUS_AW = 8;
    localparam int BIT_LSB = 7;
    localparam int DEST_BIT = 7;
    localparam int CALL_LIT_W = 11;
    localparam int LATCH_LSB = 3;
    localparam int CLK_HZ = 25000000;
    localparam int PHASES = 4;
    localparam int WDOG_PRESCALE = 16;
    localparam int STACK_DEPTH = 8;
    localparam logic [4:0] OPC_PLUS_LIT = 5'h1F;
    localparam logic [5:0] OPC_AND_LIT = 6'h39;
    localparam logic [5:0] OPC_PLUS_REG = 6'h07;
    localparam logic [5:0] OPC_AND_REG = 6'h05;
    localparam logic [5:0] OPC_CLEAR = 6'h01;
    localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
    localparam logic [3:0] OPC_BIT_CLR = 4'h4;
    localparam logic [3:0] OPC_BIT_SET = 4'h5;
    localparam logic [3:0] OPC_SKIP_LOW = 4'h6;
    localparam logic [3:0] OPC_SKIP_HIGH = 4'h7;
    localparam logic [2:0] OPC_CALL = 3'h4;
    localparam logic [13:0] WORD_KICK = 14'h0064;
    localparam logic [13:0] WORD_NOP = 14'h0000;
    localparam int ST_CARRY = 0;
    localparam int ST_DC = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_PDOWN = 3;
    localparam int ST_EXPIRY = 4;
    localparam logic [7:0] ADDR_ACC = 8'h80;
    localparam logic [7:0] ADDR_STATUS = 8'h81;
    localparam logic [7:0] ADDR_LATCH = 8'h82;
    localparam logic [7:0] ADDR_CNT_LO = 8'h83;
    localparam logic [7:0] ADDR_CNT_HI = 8'h84;
    localparam logic [7:0] ADDR_WDOG = 8'h85;
    localparam logic [7:0] ADDR_STK_LO = 8'h86;
    localparam logic [7:0] ADDR_STK_HI = 8'h87;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [12:0] PC_RST = 13'h0000;
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
    typedef enum logic [3:0] {
        OP_NOP, OP_PLUS_LIT, OP_AND_LIT, OP_PLUS_REG, OP_AND_REG, OP_BIT_CLR, OP_BIT_SET,
        OP_SKIP_LOW, OP_SKIP_HIGH, OP_CALL, OP_CLR_REG, OP_CLR_ACC, OP_KICK, OP_COMPLEMENT
    } op_t;
endpackage
`default_nettype wire

// ### core_instr_exec_add_to_complement_reg.sv
`default_nettype none
module core_instr_exec_add_to_complement_reg #(
    parameter int WDOG_PRESCALE = core_exec_pkg::WDOG_PRESCALE,
    parameter int STACK_DEPTH = core_exec_pkg::STACK_DEPTH
) (
    // clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // program memory
    output logic [12:0] progAddr,
    input wire logic [13:0] progData,
    output logic fetchStrobe,
    // register port
    input wire logic [7:0] busAddr,
    input wire logic [7:0] busWrData,
    input wire logic busWr,
    input wire logic busRd,
    output logic [7:0] busRdData,
    // watchdog
    output logic watchdogBite
);
    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam int PRE_W = $clog2(WDOG_PRESCALE);

    core_exec_pkg::phase_t phaseReg;
    core_exec_pkg::op_t opReg;
    logic [12:0] pcReg;
    logic [13:0] instrReg;
    logic [6:0] fAddrReg;
    logic [2:0] bitReg;
    logic destReg;
    logic [7:0] litReg;
    logic [10:0] callLitReg;
    logic [7:0] operandReg;
    logic [7:0] resultReg;
    logic resCarryReg;
    logic resDcReg;
    logic [7:0] accReg;
    logic [7:0] latchReg;
    logic carryFlag;
    logic dcFlag;
    logic zeroFlag;
    logic expiryFlag;
    logic powerDownFlag;
    logic [7:0] fileMem [128];
    logic [12:0] stackMem [STACK_DEPTH];
    logic [SP_W-1:0] spReg;
    logic [PRE_W-1:0] prescaleCnt;
    logic [7:0] watchdogCount;
    logic [7:0] readData;
    logic [12:0] stackTop;
    logic [12:0] callTarget;
    logic fileWrEn;
    logic accWrEn;
    logic testBit;
    logic skipTaken;
    logic flushNext;
    logic kickNow;
    logic [8:0] aluSum;
    logic [4:0] aluNib;
    logic [7:0] aluOut;
    logic [7:0] aluSrc;
    logic [7:0] litSum;

    function automatic core_exec_pkg::op_t decodeWord(input logic [13:0] w);
        core_exec_pkg::op_t op;
        op = core_exec_pkg::OP_NOP;
        if (w == core_exec_pkg::WORD_KICK) begin
            op = core_exec_pkg::OP_KICK;
        end else if (w[13:9] == core_exec_pkg::OPC_PLUS_LIT) begin
            op = core_exec_pkg::OP_PLUS_LIT;
        end else if (w[13:8] == core_exec_pkg::OPC_AND_LIT) begin
            op = core_exec_pkg::OP_AND_LIT;
        end else if (w[13:8] == core_exec_pkg::OPC_PLUS_REG) begin
            op = core_exec_pkg::OP_PLUS_REG;
        end else if (w[13:8] == core_exec_pkg::OPC_AND_REG) begin
            op = core_exec_pkg::OP_AND_REG;
        end else if (w[13:8] == core_exec_pkg::OPC_COMPLEMENT) begin
            op = core_exec_pkg::OP_COMPLEMENT;
        end else if (w[13:8] == core_exec_pkg::OPC_CLEAR) begin
            // low seven bits are ignored for the accumulator form
            op = w[core_exec_pkg::DEST_BIT] ? core_exec_pkg::OP_CLR_REG
                                            : core_exec_pkg::OP_CLR_ACC;
        end else if (w[13:10] == core_exec_pkg::OPC_BIT_CLR) begin
            op = core_exec_pkg::OP_BIT_CLR;
        end else if (w[13:10] == core_exec_pkg::OPC_BIT_SET) begin
            op = core_exec_pkg::OP_BIT_SET;
        end else if (w[13:10] == core_exec_pkg::OPC_SKIP_LOW) begin
            op = core_exec_pkg::OP_SKIP_LOW;
        end else if (w[13:10] == core_exec_pkg::OPC_SKIP_HIGH) begin
            op = core_exec_pkg::OP_SKIP_HIGH;
        end else if (w[13:11] == core_exec_pkg::OPC_CALL) begin
            op = core_exec_pkg::OP_CALL;
        end
        return op;
    endfunction

    function automatic logic isByteOp(input core_exec_pkg::op_t op);
        return op == core_exec_pkg::OP_PLUS_REG || op == core_exec_pkg::OP_AND_REG
            || op == core_exec_pkg::OP_COMPLEMENT;
    endfunction

    // phase sequencer: one instruction cycle is four clocks
    always_ff @(posedge clk) begin
        if (srst) begin
            phaseReg <= core_exec_pkg::PH_Q1;
        end else if (ce) begin
            case (phaseReg)
                core_exec_pkg::PH_Q1: phaseReg <= core_exec_pkg::PH_Q2;
                core_exec_pkg::PH_Q2: phaseReg <= core_exec_pkg::PH_Q3;
                core_exec_pkg::PH_Q3: phaseReg <= core_exec_pkg::PH_Q4;
                core_exec_pkg::PH_Q4: phaseReg <= core_exec_pkg::PH_Q1;
                default: phaseReg <= core_exec_pkg::PH_Q1;
            endcase
        end
    end

    assign readData = fileMem[fAddrReg];
    assign stackTop = stackMem[spReg - 1'b1];
    assign callTarget = {latchReg[core_exec_pkg::LATCH_LSB +: 2], callLitReg};
    assign testBit = operandReg[bitReg];
    assign skipTaken = (opReg == core_exec_pkg::OP_SKIP_LOW && !testBit)
                    || (opReg == core_exec_pkg::OP_SKIP_HIGH && testBit);
    assign flushNext = skipTaken || opReg == core_exec_pkg::OP_CALL;
    assign kickNow = phaseReg == core_exec_pkg::PH_Q4 && opReg == core_exec_pkg::OP_KICK;
    assign progAddr = pcReg;
    assign fetchStrobe = phaseReg == core_exec_pkg::PH_Q4;
    assign litSum = accReg + litReg;

    // pipeline: next word is fetched while the current one executes
    always_ff @(posedge clk) begin
        if (srst) begin
            pcReg <= core_exec_pkg::PC_RST;
            instrReg <= core_exec_pkg::WORD_NOP;
        end else if (ce && phaseReg == core_exec_pkg::PH_Q4) begin
            // a discarded fetch becomes the nop of the second cycle
            instrReg <= flushNext ? core_exec_pkg::WORD_NOP : progData;
            if (opReg == core_exec_pkg::OP_CALL) begin
                pcReg <= callTarget;
            end else begin
                pcReg <= pcReg + 13'h0001;
            end
        end
    end

    // decode in phase one; fields stay put until the next phase one
    always_ff @(posedge clk) begin
        if (srst) begin
            opReg <= core_exec_pkg::OP_NOP;
            fAddrReg <= 7'h00;
            bitReg <= 3'h0;
            destReg <= 1'b0;
            litReg <= 8'h00;
            callLitReg <= 11'h000;
        end else if (ce && phaseReg == core_exec_pkg::PH_Q1) begin
            opReg <= decodeWord(instrReg);
            fAddrReg <= instrReg[core_exec_pkg::FADDR_W-1:0];
            bitReg <= instrReg[core_exec_pkg::BIT_LSB +: 3];
            destReg <= instrReg[core_exec_pkg::DEST_BIT];
            litReg <= instrReg[core_exec_pkg::DATA_W-1:0];
            callLitReg <= instrReg[core_exec_pkg::CALL_LIT_W-1:0];
        end
    end

    // phase two reads the file register
    always_ff @(posedge clk) begin
        if (srst) begin
            operandReg <= 8'h00;
        end else if (ce && phaseReg == core_exec_pkg::PH_Q2) begin
            operandReg <= readData;
        end
    end

    always_comb begin
        aluSrc = isByteOp(opReg) ? operandReg : litReg;
        aluSum = {1'b0, accReg} + {1'b0, aluSrc};
        aluNib = {1'b0, accReg[3:0]} + {1'b0, aluSrc[3:0]};
        case (opReg)
            core_exec_pkg::OP_PLUS_LIT: aluOut = aluSum[7:0];
            core_exec_pkg::OP_PLUS_REG: aluOut = aluSum[7:0];
            core_exec_pkg::OP_AND_LIT: aluOut = accReg & litReg;
            core_exec_pkg::OP_AND_REG: aluOut = accReg & operandReg;
            core_exec_pkg::OP_BIT_CLR: aluOut = operandReg & ~(8'h01 << bitReg);
            core_exec_pkg::OP_BIT_SET: aluOut = operandReg | (8'h01 << bitReg);
            core_exec_pkg::OP_CLR_REG: aluOut = 8'h00;
            core_exec_pkg::OP_CLR_ACC: aluOut = 8'h00;
            core_exec_pkg::OP_COMPLEMENT: aluOut = ~operandReg;
            default: aluOut = operandReg;
        endcase
    end

    // phase three processes
    always_ff @(posedge clk) begin
        if (srst) begin
            resultReg <= 8'h00;
            resCarryReg <= 1'b0;
            resDcReg <= 1'b0;
        end else if (ce && phaseReg == core_exec_pkg::PH_Q3) begin
            resultReg <= aluOut;
            resCarryReg <= aluSum[8];
            resDcReg <= aluNib[4];
        end
    end

    always_comb begin
        fileWrEn = 1'b0;
        accWrEn = 1'b0;
        if (phaseReg == core_exec_pkg::PH_Q4) begin
            case (opReg)
                core_exec_pkg::OP_BIT_CLR: fileWrEn = 1'b1;
                core_exec_pkg::OP_BIT_SET: fileWrEn = 1'b1;
                core_exec_pkg::OP_CLR_REG: fileWrEn = 1'b1;
                core_exec_pkg::OP_PLUS_LIT: accWrEn = 1'b1;
                core_exec_pkg::OP_AND_LIT: accWrEn = 1'b1;
                core_exec_pkg::OP_CLR_ACC: accWrEn = 1'b1;
                // bit tests fall to default: no write at all
                default: begin
                    fileWrEn = isByteOp(opReg) && destReg;
                    accWrEn = isByteOp(opReg) && !destReg;
                end
            endcase
        end
    end

    // file registers: core write in phase four wins over a port write
    always_ff @(posedge clk) begin
        if (ce) begin
            if (fileWrEn) begin
                fileMem[fAddrReg] <= resultReg;
            end else if (busWr && !busAddr[7]) begin
                fileMem[busAddr[6:0]] <= busWrData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            accReg <= core_exec_pkg::ACC_RST;
        end else if (ce) begin
            if (accWrEn) begin
                accReg <= resultReg;
            end else if (busWr && busAddr == core_exec_pkg::ADDR_ACC) begin
                accReg <= busWrData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            latchReg <= core_exec_pkg::LATCH_RST;
        end else if (ce && busWr && busAddr == core_exec_pkg::ADDR_LATCH) begin
            latchReg <= busWrData;
        end
    end

    // arithmetic flags; bit ops, tests, call and kick leave them alone
    always_ff @(posedge clk) begin
        if (srst) begin
            carryFlag <= 1'b0;
            dcFlag <= 1'b0;
            zeroFlag <= 1'b0;
        end else if (ce) begin
            if (phaseReg == core_exec_pkg::PH_Q4 && (opReg == core_exec_pkg::OP_PLUS_LIT
                    || opReg == core_exec_pkg::OP_PLUS_REG)) begin
                carryFlag <= resCarryReg;
                dcFlag <= resDcReg;
                zeroFlag <= resultReg == 8'h00;
            end else if (phaseReg == core_exec_pkg::PH_Q4 && (opReg == core_exec_pkg::OP_AND_LIT
                    || opReg == core_exec_pkg::OP_AND_REG || opReg == core_exec_pkg::OP_CLR_REG
                    || opReg == core_exec_pkg::OP_CLR_ACC
                    || opReg == core_exec_pkg::OP_COMPLEMENT)) begin
                zeroFlag <= resultReg == 8'h00;
            end else if (busWr && busAddr == core_exec_pkg::ADDR_STATUS) begin
                carryFlag <= busWrData[core_exec_pkg::ST_CARRY];
                dcFlag <= busWrData[core_exec_pkg::ST_DC];
                zeroFlag <= busWrData[core_exec_pkg::ST_ZERO];
            end
        end
    end

    // return stack wraps silently when overfilled
    always_ff @(posedge clk) begin
        if (srst) begin
            spReg <= '0;
        end else if (ce && phaseReg == core_exec_pkg::PH_Q2
                && opReg == core_exec_pkg::OP_CALL) begin
            stackMem[spReg] <= pcReg;
            spReg <= spReg + 1'b1;
        end
    end

    // watchdog counts clocks through a prescaler; a kick beats an overflow
    always_ff @(posedge clk) begin
        if (srst) begin
            prescaleCnt <= '0;
            watchdogCount <= 8'h00;
            watchdogBite <= 1'b0;
            expiryFlag <= 1'b1;
            powerDownFlag <= 1'b1;
        end else if (ce) begin
            watchdogBite <= 1'b0;
            if (kickNow) begin
                prescaleCnt <= '0;
                watchdogCount <= 8'h00;
                expiryFlag <= 1'b1;
                powerDownFlag <= 1'b1;
            end else if (prescaleCnt == PRE_W'(WDOG_PRESCALE - 1)) begin
                prescaleCnt <= '0;
                watchdogCount <= watchdogCount + 8'h01;
                if (watchdogCount == 8'hFF) begin
                    watchdogBite <= 1'b1;
                    expiryFlag <= 1'b0;
                end
            end else begin
                prescaleCnt <= prescaleCnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            busRdData <= 8'h00;
        end else if (ce) begin
            busRdData <= 8'h00;
            if (busRd && !busAddr[7]) begin
                busRdData <= fileMem[busAddr[6:0]];
            end else if (busRd) begin
                case (busAddr)
                    core_exec_pkg::ADDR_ACC: busRdData <= accReg;
                    core_exec_pkg::ADDR_STATUS: busRdData <= {3'h0, expiryFlag, powerDownFlag,
                                                              zeroFlag, dcFlag, carryFlag};
                    core_exec_pkg::ADDR_LATCH: busRdData <= latchReg;
                    core_exec_pkg::ADDR_CNT_LO: busRdData <= pcReg[7:0];
                    core_exec_pkg::ADDR_CNT_HI: busRdData <= {3'h0, pcReg[12:8]};
                    core_exec_pkg::ADDR_WDOG: busRdData <= watchdogCount;
                    core_exec_pkg::ADDR_STK_LO: busRdData <= stackTop[7:0];
                    core_exec_pkg::ADDR_STK_HI: busRdData <= {3'h0, stackTop[12:8]};
                    default: busRdData <= 8'h00;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic atQ4;
    assign atQ4 = ce && phaseReg == core_exec_pkg::PH_Q4;

    a_lit_add_sum: assert property (atQ4 && opReg == core_exec_pkg::OP_PLUS_LIT
        |=> accReg == $past(litSum) && zeroFlag == ($past(litSum) == 8'h00))
        else $error("literal add result wrong");
    a_and_lit_flags: assert property (atQ4 && opReg == core_exec_pkg::OP_AND_LIT
        |=> $stable(carryFlag) && $stable(dcFlag) && accReg == $past(resultReg))
        else $error("literal and touched carry");
    a_dest_route: assert property (atQ4 && isByteOp(opReg)
        |-> fileWrEn == destReg && accWrEn == !destReg)
        else $error("destination routing wrong");
    a_bit_op_write: assert property (atQ4 && (opReg == core_exec_pkg::OP_BIT_CLR
        || opReg == core_exec_pkg::OP_BIT_SET)
        |=> readData[bitReg] == (opReg == core_exec_pkg::OP_BIT_SET) && $stable(zeroFlag))
        else $error("bit not forced");
    a_read_phase_two: assert property (ce && phaseReg == core_exec_pkg::PH_Q2
        |=> operandReg == $past(readData))
        else $error("operand not read in phase two");
    a_skip_flush: assert property (atQ4 && skipTaken
        |=> instrReg == core_exec_pkg::WORD_NOP)
        else $error("skipped word not discarded");
    a_test_no_write: assert property (ce && (opReg == core_exec_pkg::OP_SKIP_LOW
        || opReg == core_exec_pkg::OP_SKIP_HIGH) |-> !fileWrEn && !accWrEn)
        else $error("bit test wrote a register");
    a_call_push: assert property (ce && phaseReg == core_exec_pkg::PH_Q2
        && opReg == core_exec_pkg::OP_CALL |=> stackTop == $past(pcReg))
        else $error("return address not pushed");
    a_call_target: assert property (atQ4 && opReg == core_exec_pkg::OP_CALL
        |=> pcReg == $past(callTarget) && instrReg == core_exec_pkg::WORD_NOP)
        else $error("call target wrong");
    a_clear_zero: assert property (atQ4 && (opReg == core_exec_pkg::OP_CLR_REG
        || opReg == core_exec_pkg::OP_CLR_ACC) |=> zeroFlag)
        else $error("clear did not set zero");
    a_kick_reset: assert property (kickNow && ce
        |=> watchdogCount == 8'h00 && prescaleCnt == '0 && expiryFlag && powerDownFlag)
        else $error("kick did not reset watchdog");
    a_phase_cycle: assert property (ce && phaseReg == core_exec_pkg::PH_Q1
        ##1 ce [*3] |=> phaseReg == core_exec_pkg::PH_Q1)
        else $error("instruction cycle not four clocks");

    c_call_seen: cover property (atQ4 && opReg == core_exec_pkg::OP_CALL);
    c_skip_low: cover property (atQ4 && opReg == core_exec_pkg::OP_SKIP_LOW && skipTaken);
    c_add_carry: cover property (atQ4 && opReg == core_exec_pkg::OP_PLUS_REG && resCarryReg);
    c_kick_seen: cover property (kickNow && ce);
endmodule // core_instr_exec_add_to_complement_reg
`default_nettype wire

// ### prog_mem_model.sv
`default_nettype none
module prog_mem_model (
    // fetch port
    input wire logic [12:0] progAddr,
    output logic [13:0] progData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] mem [64];
    // image repeats every 64 words, so far call targets land on blank words
    initial begin
        foreach (mem[i]) begin
            mem[i] = core_exec_pkg::WORD_NOP;
        end
    end
    assign progData = mem[progAddr[5:0]];
endmodule // prog_mem_model
`default_nettype wire

// ### tb_core_instr_exec_add_to_complement_reg.sv
`default_nettype none
module tb_core_instr_exec_add_to_complement_reg;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] OPS [12] = '{14'h3E00, 14'h3900, 14'h0700, 14'h0500, 14'h0100,
        14'h0900, 14'h1000, 14'h1400, 14'h1800, 14'h1C00, 14'h2000, 14'h0064};
    localparam int FIX [12] = '{5, 6, 6, 6, 6, 6, 4, 4, 4, 4, 3, 14};
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic ce = 1'h1;
    logic [12:0] progAddr;
    logic [13:0] progData;
    logic fetchStrobe;
    logic [7:0] busAddr = 8'h00;
    logic [7:0] busWrData = 8'h00;
    logic busWr = 1'h0;
    logic busRd = 1'h0;
    logic [7:0] busRdData;
    logic watchdogBite;
    logic [12:0] fetched [$];
    int errors = 0;
    int num_checks = 0;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        // a frozen phase four holds the strobe up without taking a word
        if (fetchStrobe && ce && !srst) begin
            fetched.push_back(progAddr);
        end
    end
    core_instr_exec_add_to_complement_reg #(.WDOG_PRESCALE(2)) DUT (.clk(clk), .srst(srst), .ce(ce),
        .progAddr(progAddr), .progData(progData), .fetchStrobe(fetchStrobe),
        .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
        .busRdData(busRdData), .watchdogBite(watchdogBite));
    prog_mem_model mem_i (.progAddr(progAddr), .progData(progData));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // strobes are left up so back-to-back transfers never assign twice in one step
    task automatic xfer(input logic rd, input logic [7:0] a, d, output logic [7:0] q);
        busRd <= rd;
        busWr <= !rd;
        busAddr <= a;
        busWrData <= d;
        @(posedge clk);
        #1;
        q = busRdData;
    endtask
    function automatic logic [19:0] predict(logic [13:0] w, logic [7:0] a, f, logic [2:0] st);
        logic [8:0] s;
        logic [7:0] o;
        logic [7:0] v;
        logic m;
        logic hit;
        v = w[13] ? w[7:0] : f;
        s = a + v;
        m = 1'h1;
        hit = 1'h1;
        o = 8'h00;
        case (w[13:8])
            6'h3E, 6'h3F, 6'h07: o = s[7:0];
            6'h39, 6'h05: o = a & v;
            6'h01: o = 8'h00;
            6'h09: o = ~f;
            default: hit = 1'h0;
        endcase
        if (hit) begin
            st[2] = o == 8'h00;
            if (w[13:9] == 5'h1F || w[13:8] == 6'h07) begin
                st[1:0] = {a[3:0] + v[3:0] > 5'h0F, s[8]};
            end
            if (w[13] || !w[7]) begin
                a = o;
            end else begin
                f = o;
            end
        end
        if (w[13:12] == 2'h1) begin
            case (w[11:10])
                2'h0: f[w[9:7]] = 1'h0;
                2'h1: f[w[9:7]] = 1'h1;
                2'h2: m = f[w[9:7]];
                default: m = !f[w[9:7]];
            endcase
        end
        if (w[13:11] == 3'h4) begin
            m = 1'h0;
        end
        return {m, a, f, st};
    endfunction
    // word under test sits at 1; word 2 sets a marker bit unless it is discarded
    task automatic run(input logic [13:0] w, input logic [7:0] a, f, lt, input logic [2:0] st);
        logic [19:0] e;
        logic [7:0] q;
        e = predict(w, a, f, st);
        srst <= 1'h1;
        repeat (12) @(posedge clk);
        // image is loaded under reset, after the model's own time-zero fill
        mem_i.mem[1] = w;
        mem_i.mem[2] = 14'h147F;
        srst <= 1'h0;
        fetched.delete();
        @(posedge clk);
        #1;
        xfer(1'h0, {1'h0, w[6:0]}, f, q);
        xfer(1'h0, 8'h80, a, q);
        xfer(1'h0, 8'h81, {5'h00, st}, q);
        xfer(1'h0, 8'h82, lt, q);
        xfer(1'h0, 8'h7F, 8'h00, q);
        busWr <= 1'h0;
        // freeze the core now and then; it must still finish within the wait
        for (int n = 0; n < 24; n++) begin
            @(posedge clk);
            ce <= n > 19 || n % 3 != 0;
        end
        #1;
        xfer(1'h1, 8'h80, 8'h00, q);
        check(q, e[18:11]);
        xfer(1'h1, {1'h0, w[6:0]}, 8'h00, q);
        check(q, e[10:3]);
        xfer(1'h1, 8'h81, 8'h00, q);
        check(q, {5'h03, e[2:0]});
        xfer(1'h1, 8'h7F, 8'h00, q);
        check(q, {7'h00, e[19]});
        xfer(1'h1, 8'h86, 8'h00, q);
        busRd <= 1'h0;
        if (w[13:11] == 3'h4) begin
            check(q, 8'h02);
            check(fetched[3], {lt[4:3], w[10:0]});
        end
        $display("run %h done", w);
    endtask
    task automatic wdog(input logic [13:0] w, input logic bite);
        logic seen;
        logic [7:0] q;
        seen = 1'h0;
        // the word under test fills the image so a kick keeps coming back
        for (int i = 3; i < 64; i++) begin
            mem_i.mem[i] = w;
        end
        run(w, 8'h5A, 8'h00, 8'h00, 3'h0);
        repeat (600) begin
            @(posedge clk);
            #1;
            seen = seen | watchdogBite;
        end
        check(seen, bite);
        xfer(1'h1, 8'h81, 8'h00, q);
        busRd <= 1'h0;
        check(q[4:3], {!bite, 1'h1});
    endtask
    initial begin
        #2ms;
        check(16'h0000, 16'h0001);
        end_of_test();
    end
    initial begin
        logic [13:0] w;
        int j;
        void'($urandom(34));
        run(14'h3E01, 8'hFF, 8'h00, 8'h00, 3'h0);
        run(14'h1F80, 8'h00, 8'h80, 8'h00, 3'h5);
        for (int i = 0; i < 60; i++) begin
            j = i % 12;
            w = 14'($urandom);
            w = (w & ~(14'h3FFF << (14 - FIX[j]))) | OPS[j];
            if (w[13:11] == 3'h4) begin
                w[5] = 1'h1;
            end
            if (w[6:0] == 7'h7F) begin
                w[6] = 1'h0;
            end
            run(w, 8'($urandom), 8'($urandom), 8'($urandom), 3'($urandom));
        end
        wdog(14'h0000, 1'h1);
        wdog(core_exec_pkg::WORD_KICK, 1'h0);
        end_of_test();
    end
endmodule // tb_core_instr_exec_add_to_complement_reg
`default_nettype wire
